// ==== common/accr_defs.vh ====
// Register map, field positions and reset values of the calibration control registers.
`ifndef ACCR_DEFS_VH
`define ACCR_DEFS_VH

// Register indices as printed; the byte address is four times the index.
`define ACCR_IDX_ENABLE        8'h61
`define ACCR_IDX_CFG_PRIMARY   8'h62
`define ACCR_IDX_CFG_SECONDARY 8'h65
`define ACCR_IDX_AVERAGING     8'h68
`define ACCR_IDX_STATUS        8'h6a
`define ACCR_IDX_LINK          8'h70

// Reset values.
`define ACCR_RST_ENABLE        8'h01
`define ACCR_RST_CFG_PRIMARY   8'h01
`define ACCR_RST_CFG_SECONDARY 8'h01
`define ACCR_RST_AVERAGING     8'h61
`define ACCR_RST_LINK          8'h00
`define ACCR_RST_FG_EN         1'b1
`define ACCR_RST_OFFSET_AVERAGING_LEVEL        3'h6
`define ACCR_RST_LIN_AVG       3'h1

// Field positions.
`define ACCR_BIT_RUN           0
`define ACCR_BIT_FG            0
`define ACCR_BIT_BG            1
`define ACCR_BIT_FG_OS         2
`define ACCR_BIT_BG_OS         3
`define ACCR_BIT_OFFSET_REFERENCE_SELECT         2
`define ACCR_BIT_LINK          0
`define ACCR_BIT_FOREGROUND_DONE_FLAG       0
`define ACCR_OFFSET_AVERAGING_LEVEL_HI         6
`define ACCR_OFFSET_AVERAGING_LEVEL_LO         4
`define ACCR_LIN_AVG_HI        2
`define ACCR_LIN_AVG_LO        0

// Byte address fields: the word index and the top bits that must be zero.
`define ACCR_ADDR_IDX_HI       9
`define ACCR_ADDR_IDX_LO       2
`define ACCR_ADDR_TOP_HI       11
`define ACCR_ADDR_TOP_LO       10
`define ACCR_ADDR_TOP_NONE     2'b00

// AXI responses.
`define ACCR_RESP_OKAY         2'b00
`define ACCR_RESP_SLVERR       2'b10

`endif

// ==== design/accr_regs.v ====
// AXI4-Lite register bank that steers the converter calibration engine.
// How it works
// [RL1] Calibration runs while the run enable bit, bit 0, reset 1, is high.
// [RL2] Run enable low holds the calibration engine in reset for reprogramming.
// [RL3] Run enable low also resets the processing and link clock dividers.
// [RL4] Software clears run enable before changing settings, then sets it to rerun.
// [RL5] Software raises run enable before link enable, lowers link enable first.
// [RL6] Software writes reserved fields with their reset values.
// [RL7] Bit 3 enables background offset calibration, only with background enabled.
// [RL8] Bit 2 enables foreground offset calibration, only with foreground enabled.
// [RL9] Bit 1 enables background calibration, reset 0.
// [RL10] Bit 0 resets values then runs foreground calibration; 0 skips it.
// [RL11] Offset reference 0 calibrates offsets to mid-code, zero offset.
// [RL12] Offset reference 1 matches primary offsets to the spare converter.
// [RL13] Software selects offset reference 1 only with background calibration on; offset_reference_select is copied out without that gate.
// [RL14] Bits 6:4 of averaging select offset averaging, reset 6.
// [RL15] Bits 2:0 of averaging select linearity averaging, reset 1.
// [RL16] Foreground done flag rises once foreground calibration completed or skipped.
// [RL17] Settings persist across run enable changes, take effect at next run.

// Only byte lane 0 of a write carries register data; the upper lanes are ignored
// and read back as zero. Reserved bits are stored as written, so software that
// keeps to the reserved-value rule reads back exactly what it wrote.
// Engine settings are copied out only while the run enable is low. This trades a
// little latency for a guarantee that the engine never sees a half-changed setup.
`timescale 1ns/1ps
`include "accr_defs.vh"

module accr_regs #(
  parameter FG_CAL_CYCLES = 16
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         cal_engine_reset_n,
  output reg         divider_reset_n,
  output reg         serial_link_enable,
  output reg         foreground_cal_enable,
  output reg         background_cal_enable,
  output reg         foreground_offset_cal_enable,
  output reg         background_offset_cal_enable,
  output reg         offset_reference_select,
  output reg  [2:0]  offset_averaging_level,
  output reg  [2:0]  linearity_averaging_level,
  output reg         foreground_done_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage and decode helpers.

  reg  [7:0]  calibration_enable;
  reg  [7:0]  calibration_config_primary;
  reg  [7:0]  calibration_config_secondary;
  reg  [7:0]  calibration_averaging;
  reg  [7:0]  link_control;
  reg  [11:0] wr_addr;
  reg  [31:0] wr_data;
  reg  [3:0]  wr_strb;
  reg         have_aw;
  reg         have_w;
  reg  [15:0] fg_count;
  reg         fg_running;
  reg  [31:0] next_rdata;
  reg         next_rhit;
  wire        do_write;
  wire        run;
  wire [7:0]  wbyte;

  // Last count of a foreground run; a zero-length run would wrap, so the
  // parameter must stay at one or more.
  localparam [15:0] FG_LAST = FG_CAL_CYCLES[15:0] - 16'h0001;

  // Word index from a byte address; the low two bits are ignored.
  function [7:0] word_index;
    input [11:0] addr;
    begin
      word_index = addr[`ACCR_ADDR_IDX_HI:`ACCR_ADDR_IDX_LO];
    end
  endfunction

  // True when the address lands on the given register index.
  function hit;
    input [11:0] addr;
    input [7:0]  idx;
    begin
      hit = (addr[`ACCR_ADDR_TOP_HI:`ACCR_ADDR_TOP_LO] == `ACCR_ADDR_TOP_NONE) &&
            (word_index(addr) == idx);
    end
  endfunction

  // True when the address lands on any implemented register.
  function is_mapped;
    input [11:0] addr;
    begin
      is_mapped = hit(addr, `ACCR_IDX_ENABLE) ||
                  hit(addr, `ACCR_IDX_CFG_PRIMARY) ||
                  hit(addr, `ACCR_IDX_CFG_SECONDARY) ||
                  hit(addr, `ACCR_IDX_AVERAGING) ||
                  hit(addr, `ACCR_IDX_STATUS) ||
                  hit(addr, `ACCR_IDX_LINK);
    end
  endfunction

  // A write fires only with both halves in and no response still waiting, so a
  // slow master can never lose a response.
  assign run      = calibration_enable[`ACCR_BIT_RUN];
  assign do_write = have_aw && have_w && !s_axi_bvalid;
  assign wbyte    = wr_strb[0] ? wr_data[7:0] : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are caught in either order.
  // Each ready is a one-cycle pulse raised the cycle after its valid is seen, so
  // a held valid is never taken twice. The response is raised once both halves
  // are in and stands until the master takes it; a new write waits for that.

  always @(posedge aclk) begin
    if (!aresetn) begin
      have_aw       <= 1'b0;
      have_w        <= 1'b0;
      wr_addr       <= 12'h000;
      wr_data       <= 32'h0000_0000;
      wr_strb       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ACCR_RESP_OKAY;
    end else begin
      s_axi_awready <= !have_aw && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !have_w && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        have_aw <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        have_w  <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      // The register lands in the same cycle as the response is raised.
      if (do_write) begin
        have_aw      <= 1'b0;
        have_w       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Unmapped addresses answer with an error and change nothing.
        s_axi_bresp  <= is_mapped(wr_addr) ? `ACCR_RESP_OKAY : `ACCR_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage. Only byte lane 0 carries data; a write without it keeps
  // the old value. Stored fields survive any run enable change. [RL17]
  // Writes to the status word are dropped here, since the done flag is driven
  // only by the foreground sequence below.

  always @(posedge aclk) begin
    if (!aresetn) begin
      calibration_enable           <= `ACCR_RST_ENABLE;          // [RL1]
      calibration_config_primary   <= `ACCR_RST_CFG_PRIMARY;
      calibration_config_secondary <= `ACCR_RST_CFG_SECONDARY;
      calibration_averaging        <= `ACCR_RST_AVERAGING;       // [RL14] [RL15]
      link_control                 <= `ACCR_RST_LINK;
    end else if (do_write && wr_strb[0]) begin
      if (hit(wr_addr, `ACCR_IDX_ENABLE))
        calibration_enable <= wbyte;
      if (hit(wr_addr, `ACCR_IDX_CFG_PRIMARY))
        calibration_config_primary <= wbyte;
      if (hit(wr_addr, `ACCR_IDX_CFG_SECONDARY))
        calibration_config_secondary <= wbyte;
      if (hit(wr_addr, `ACCR_IDX_AVERAGING))
        calibration_averaging <= wbyte;
      if (hit(wr_addr, `ACCR_IDX_LINK))
        link_control <= wbyte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Engine controls. Settings are latched into the engine only while the run
  // enable is low, so a change made mid-run waits for the next run. [RL17]
  // The engine leaves reset one cycle after the run enable rises, so the copied
  // settings are already settled when it starts.

  always @(posedge aclk) begin
    if (!aresetn) begin
      cal_engine_reset_n           <= 1'b0;
      divider_reset_n              <= 1'b0;
      serial_link_enable           <= 1'b0;
      foreground_cal_enable        <= `ACCR_RST_FG_EN;
      background_cal_enable        <= 1'b0;
      foreground_offset_cal_enable <= 1'b0;
      background_offset_cal_enable <= 1'b0;
      offset_reference_select      <= 1'b0;
      offset_averaging_level       <= `ACCR_RST_OFFSET_AVERAGING_LEVEL;
      linearity_averaging_level    <= `ACCR_RST_LIN_AVG;
    end else begin
      cal_engine_reset_n <= run;                                  // [RL1] [RL2]
      divider_reset_n    <= run;                                  // [RL3]
      // The link is gated by run so a wrong software order cannot clock it dead.
      serial_link_enable <= run && link_control[`ACCR_BIT_LINK];  // [RL5]
      if (!run) begin
        foreground_cal_enable <= calibration_config_primary[`ACCR_BIT_FG];    // [RL10]
        background_cal_enable <= calibration_config_primary[`ACCR_BIT_BG];    // [RL9]
        foreground_offset_cal_enable <= calibration_config_primary[`ACCR_BIT_FG_OS] &&
                                        calibration_config_primary[`ACCR_BIT_FG]; // [RL8]
        background_offset_cal_enable <= calibration_config_primary[`ACCR_BIT_BG_OS] &&
                                        calibration_config_primary[`ACCR_BIT_BG]; // [RL7]
        // Select 0 aims at mid-code, 1 follows the spare converter. [RL11] [RL12]
        offset_reference_select <= calibration_config_secondary[`ACCR_BIT_OFFSET_REFERENCE_SELECT];
        offset_averaging_level <=
          calibration_averaging[`ACCR_OFFSET_AVERAGING_LEVEL_HI:`ACCR_OFFSET_AVERAGING_LEVEL_LO];            // [RL14]
        linearity_averaging_level <=
          calibration_averaging[`ACCR_LIN_AVG_HI:`ACCR_LIN_AVG_LO];          // [RL15]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Foreground sequence: values reset, then a fixed-length run or a skip.
  // The done flag drops whenever the engine is held, so a stale done from an
  // earlier run can never be read after a rerun is requested.

  always @(posedge aclk) begin
    if (!aresetn) begin
      fg_running           <= 1'b0;
      fg_count             <= 16'h0000;
      foreground_done_flag <= 1'b0;
    end else if (!cal_engine_reset_n) begin
      fg_running           <= 1'b1;
      fg_count             <= 16'h0000;
      foreground_done_flag <= 1'b0;
    end else if (fg_running) begin
      // A skipped run still passes through here once, so done always follows
      // the engine release by at least one cycle.
      if (!foreground_cal_enable || fg_count == FG_LAST) begin
        fg_running           <= 1'b0;
        foreground_done_flag <= 1'b1;                              // [RL16] [RL10]
      end else begin
        fg_count <= fg_count + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel, one read at a time.
  // The read data is captured with the address handshake, so it is a snapshot
  // and does not follow the register while rvalid waits for rready. Unmapped
  // reads return zero with an error response.

  always @* begin
    next_rdata = 32'h0000_0000;
    next_rhit  = 1'b1;
    if (hit(s_axi_araddr, `ACCR_IDX_ENABLE))
      next_rdata[7:0] = calibration_enable;
    else if (hit(s_axi_araddr, `ACCR_IDX_CFG_PRIMARY))
      next_rdata[7:0] = calibration_config_primary;
    else if (hit(s_axi_araddr, `ACCR_IDX_CFG_SECONDARY))
      next_rdata[7:0] = calibration_config_secondary;
    else if (hit(s_axi_araddr, `ACCR_IDX_AVERAGING))
      next_rdata[7:0] = calibration_averaging;
    else if (hit(s_axi_araddr, `ACCR_IDX_STATUS))
      next_rdata[`ACCR_BIT_FOREGROUND_DONE_FLAG] = foreground_done_flag;
    else if (hit(s_axi_araddr, `ACCR_IDX_LINK))
      next_rdata[7:0] = link_control;
    else
      next_rhit = 1'b0;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ACCR_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= next_rhit ? `ACCR_RESP_OKAY : `ACCR_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ==== tb/accr_regs_chk.sv ====
// Port checks for the calibration register bank.
`timescale 1ns/1ps
module accr_regs_chk #(
  parameter FG_CAL_CYCLES = 16
) (
  input logic        aclk,
  input logic        aresetn,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        cal_engine_reset_n,
  input logic        divider_reset_n,
  input logic        serial_link_enable,
  input logic        foreground_cal_enable,
  input logic        background_cal_enable,
  input logic        foreground_offset_cal_enable,
  input logic        background_offset_cal_enable,
  input logic        offset_reference_select,
  input logic [2:0]  offset_averaging_level,
  input logic [2:0]  linearity_averaging_level,
  input logic        foreground_done_flag
);
  // A few spare cycles cover the start-up latency of the engine model.
  localparam int FG_MAX = FG_CAL_CYCLES + 4;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  a_run_resets: assert property (cal_engine_reset_n == divider_reset_n)
    else $error("divider reset differs from engine reset");
  a_link_needs_run: assert property (serial_link_enable |-> cal_engine_reset_n)
    else $error("serial link enabled while calibration held");
  a_bg_os_gated: assert property (background_offset_cal_enable |-> background_cal_enable)
    else $error("background offset without background calibration");
  a_fg_os_gated: assert property (foreground_offset_cal_enable |-> foreground_cal_enable)
    else $error("foreground offset without foreground calibration");
  a_cfg_hold_run: assert property (cal_engine_reset_n && $past(cal_engine_reset_n) |->
    $stable({background_cal_enable, foreground_cal_enable, offset_reference_select,
    offset_averaging_level, linearity_averaging_level}))
    else $error("settings changed during a run");
  a_done_clears: assert property (!cal_engine_reset_n [*2] |-> !foreground_done_flag)
    else $error("done flag high while calibration held");
  a_foreground_done_flag_time: assert property ($rose(cal_engine_reset_n) && foreground_cal_enable |->
    ##[1:FG_MAX] foreground_done_flag)
    else $error("foreground run did not finish in time");
  a_fg_skip_fast: assert property ($rose(cal_engine_reset_n) && !foreground_cal_enable |->
    ##[1:3] foreground_done_flag)
    else $error("skipped foreground run did not report done");
  a_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not returned after address");
  a_rd_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  c_done: cover property ($rose(foreground_done_flag));
  c_bg_run: cover property (cal_engine_reset_n && background_offset_cal_enable);
  c_link: cover property ($rose(serial_link_enable));
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the calibration register bank.
`timescale 1ns/1ps
`include "accr_defs.vh"
module tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, cal_engine_reset_n, divider_reset_n, serial_link_enable;
  logic        foreground_cal_enable, background_cal_enable, foreground_offset_cal_enable;
  logic        background_offset_cal_enable, offset_reference_select, foreground_done_flag;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [2:0]  offset_averaging_level, linearity_averaging_level;
  int          num_errors = 0;
  int          samples_checked = 0;
  // Byte addresses are four times the register index.
  localparam logic [11:0] ad_en = 12'h184, ad_c0 = 12'h188, ad_c1 = 12'h194;
  localparam logic [11:0] ad_avg = 12'h1a0, ad_st = 12'h1a8, ad_lk = 12'h1c0;
  accr_regs #(.FG_CAL_CYCLES(16)) uut (.*);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // A handshake that never comes ends the run instead of hanging it.
  task automatic hang();
    chk(32'h0, 32'h1);
    give_verdict();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Address and data go out together; each drops when its own ready is seen.
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    repeat (100) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    if (s_axi_bvalid !== 1'h1) hang();
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rdr(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    repeat (100) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    if (s_axi_rvalid !== 1'h1) hang();
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic wrk(input logic [11:0] a, input logic [7:0] d);
    wr(a, d, 4'h1);
    chk(rs, `ACCR_RESP_OKAY);
    tick(3);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    rdr(a);
    chk(rd, {24'h0, e});
    chk(rs, `ACCR_RESP_OKAY);
  endtask
  task automatic wait_done();
    repeat (100) begin
      @(posedge aclk);
      if (foreground_done_flag) break;
    end
    if (foreground_done_flag !== 1'h1) hang();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({cal_engine_reset_n, divider_reset_n}, 2'h3);
    wait_done();
    chk({offset_averaging_level, linearity_averaging_level}, 6'h31);
    chk({background_cal_enable, foreground_cal_enable}, 2'h1);
    rchk(ad_en, 8'h01);
    rchk(ad_c0, 8'h01);
    rchk(ad_c1, 8'h01);
    rchk(ad_avg, 8'h61);
    $display("test reset done");
  endtask
  task automatic t_reprog();
    wrk(ad_en, 8'h00);
    chk({cal_engine_reset_n, divider_reset_n, foreground_done_flag}, 3'h0);
    wrk(ad_c0, 8'h0f);
    wrk(ad_c1, 8'h05);
    wrk(ad_avg, 8'h35);
    wrk(ad_en, 8'h01);
    wait_done();
    chk({background_offset_cal_enable, foreground_offset_cal_enable,
      background_cal_enable, foreground_cal_enable, offset_reference_select}, 5'h1f);
    chk({offset_averaging_level, linearity_averaging_level}, 6'h1d);
    wrk(ad_en, 8'h00);
    wrk(ad_en, 8'h01);
    rchk(ad_c0, 8'h0f);
    rchk(ad_c1, 8'h05);
    $display("test reprogram done");
  endtask
  task automatic t_gate();
    wrk(ad_en, 8'h00);
    wrk(ad_c1, 8'h01);
    wrk(ad_c0, 8'h0c);
    wrk(ad_en, 8'h01);
    chk({background_offset_cal_enable, foreground_offset_cal_enable,
      background_cal_enable, foreground_cal_enable, offset_reference_select}, 5'h00);
    chk(foreground_done_flag, 1'h1);
    $display("test gating done");
  endtask
  task automatic t_link();
    wrk(ad_lk, 8'h01);
    chk(serial_link_enable, 1'h1);
    wrk(ad_lk, 8'h00);
    chk(serial_link_enable, 1'h0);
    wrk(ad_en, 8'h00);
    wrk(ad_lk, 8'h01);
    chk(serial_link_enable, 1'h0);
    wrk(ad_lk, 8'h00);
    wrk(ad_en, 8'h01);
    $display("test link done");
  endtask
  task automatic t_bus();
    wr(12'hc00, 8'h5a, 4'h1);
    chk(rs, `ACCR_RESP_SLVERR);
    rdr(12'hc00);
    chk(rd, 32'h0);
    chk(rs, `ACCR_RESP_SLVERR);
    wr(ad_avg, 8'h00, 4'h0);
    chk(rs, `ACCR_RESP_OKAY);
    rchk(ad_avg, 8'h35);
    wait_done();
    wrk(ad_st, 8'h00);
    rchk(ad_st, 8'h01);
    $display("test bus done");
  endtask
  // Reset in mid-run, then a setting changed during a run waits for the rerun.
  task automatic t_rerst();
    @(posedge aclk);
    aresetn <= 1'h0;
    tick(4);
    aresetn <= 1'h1;
    tick(2);
    chk({cal_engine_reset_n, serial_link_enable, foreground_done_flag}, 3'h4);
    chk({offset_averaging_level, linearity_averaging_level}, 6'h31);
    rchk(ad_c0, 8'h01);
    rchk(ad_avg, 8'h61);
    wait_done();
    wrk(ad_avg, 8'h35);
    chk({offset_averaging_level, linearity_averaging_level}, 6'h31);
    wrk(ad_en, 8'h00);
    wrk(ad_en, 8'h01);
    chk({offset_averaging_level, linearity_averaging_level}, 6'h1d);
    $display("test mid-run reset done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
      s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    tick(4);
    aresetn <= 1'h1;
    tick(2);
    t_reset();
    t_reprog();
    t_gate();
    t_link();
    t_bus();
    t_rerst();
    give_verdict();
  end
endmodule
bind accr_regs accr_regs_chk #(.FG_CAL_CYCLES(FG_CAL_CYCLES)) chk_i (.*);
